//--- rtl/err_count_if.sv
// Carrier between the control bank and its error counter.
`default_nettype none
interface err_count_if;
   maint_pkg::err_sel_t sel;
   logic transfer;
   logic [maint_pkg::CNT_W-1:0] result;
   logic saturated;
   modport ctrl(output sel, output transfer, input result, input saturated);
   modport counter(input sel, input transfer, output result,
      output saturated);
endinterface
`default_nettype wire

//--- rtl/error_counter.sv
// Saturating 16-bit error counter with result snapshot.
`default_nettype none
module error_counter (
   input wire logic clk,
   input wire logic nrst,
   err_count_if.counter cnt,
   input wire logic err_logic,
   input wire logic err_exz,
   input wire logic err_cv
);
   logic [maint_pkg::CNT_W-1:0] count_reg, count_next;
   logic [maint_pkg::CNT_W-1:0] result_reg, result_next;
   logic [maint_pkg::CNT_W-1:0] base;
   logic [maint_pkg::CNT_W:0] sum;
   logic [1:0] inc;

   always_comb begin
      case (cnt.sel)
         maint_pkg::ERR_SEL_LOGIC: inc = {1'b0, err_logic}; // RQ10
         maint_pkg::ERR_SEL_EXZ: inc = {1'b0, err_exz}; // RQ10
         maint_pkg::ERR_SEL_CV: inc = {1'b0, err_cv}; // RQ10
         maint_pkg::ERR_SEL_BOTH: inc = {1'b0, err_cv} + {1'b0, err_exz};
         default: inc = 2'h0;
      endcase
      // Events in the transfer cycle land in the fresh count, not lost.
      base = cnt.transfer ? '0 : count_reg; // RQ12
      sum = {1'b0, base} + {15'h0000, inc};
      count_next = sum[maint_pkg::CNT_W] ? '1 : sum[maint_pkg::CNT_W-1:0];
      result_next = cnt.transfer ? count_reg : result_reg; // RQ12
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= '0;
         result_reg <= '0;
      end else begin
         count_reg <= count_next;
         result_reg <= result_next;
      end
   end

   assign cnt.result = result_reg;
   assign cnt.saturated = &count_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   xfer_copy_a: assert property ( // RQ12
      cnt.transfer |=> cnt.result == $past(count_reg) && count_reg <= 16'h0002)
      else $error("Transfer did not copy and reset the count.");
   sel_both_a: assert property ( // RQ10
      cnt.sel == maint_pkg::ERR_SEL_BOTH && err_cv && err_exz
      && !cnt.transfer && count_reg < 16'hFFF0
      |=> count_reg == $past(count_reg) + 16'h0002)
      else $error("Both sources did not add two.");
   sel_logic_a: assert property ( // RQ10
      cnt.sel == maint_pkg::ERR_SEL_LOGIC && !err_logic && !cnt.transfer
      |=> $stable(count_reg))
      else $error("Count moved with no selected error.");
endmodule
`default_nettype wire

//--- rtl/inband_loop_code_and_error_count_ctrl.sv
// Top of the in-band loop code and error count control bank.
`default_nettype none
module inband_loop_code_and_error_count_ctrl #(
   parameter int unsigned ONE_SEC_CYCLES = maint_pkg::ONE_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [maint_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [maint_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [maint_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [1:0] tx_pattern_select,
   input wire logic tx_bit_en,
   output logic tx_code_active,
   output logic tx_code_bit,
   output logic violation_strobe,
   output logic logic_error_strobe,
   output logic [maint_pkg::DATA_W-1:0] rx_activate_code,
   output logic [1:0] rx_activate_length,
   output logic [maint_pkg::DATA_W-1:0] rx_deactivate_code,
   output logic [1:0] rx_deactivate_length,
   output logic excess_zero_def,
   input wire logic err_logic,
   input wire logic err_excess_zero,
   input wire logic err_code_violation,
   output logic count_full
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Keeps the low N bits of a code, N being five plus the length field.
   function automatic logic [7:0] code_mask(input logic [1:0] len);
      code_mask = maint_pkg::MASK_FULL >> (maint_pkg::LEN_MAX - len);
   endfunction

   function automatic logic [2:0] last_idx(input logic [1:0] len);
      last_idx = {1'b0, len} + maint_pkg::LAST_IDX_MIN;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] lengths_reg, lengths_next;
   logic [7:0] txcode_reg, txcode_next;
   logic [7:0] rxact_reg, rxact_next;
   logic [7:0] rxdeact_reg, rxdeact_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] rdata_reg, rdata_next;

   err_count_if cnt ();

   always_comb begin
      lengths_next = lengths_reg;
      txcode_next = txcode_reg;
      rxact_next = rxact_reg;
      rxdeact_next = rxdeact_reg;
      ctrl_next = ctrl_reg;
      if (reg_wr) begin
         case (reg_addr)
            maint_pkg::OFF_LENGTHS: begin
               lengths_next = reg_wdata & maint_pkg::MASK_LENGTHS; // RQ16
            end
            maint_pkg::OFF_TX_CODE: begin
               txcode_next = reg_wdata;
            end
            maint_pkg::OFF_RX_ACT: begin
               rxact_next = reg_wdata;
            end
            maint_pkg::OFF_RX_DEACT: begin
               rxdeact_next = reg_wdata;
            end
            maint_pkg::OFF_ERR_CTRL: begin
               ctrl_next = reg_wdata & maint_pkg::MASK_ERR_CTRL; // RQ16
            end
            default: begin
               ctrl_next = ctrl_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lengths_reg <= maint_pkg::RST_LENGTHS; // RQ3
         txcode_reg <= maint_pkg::RST_TX_CODE;
         rxact_reg <= maint_pkg::RST_RX_ACT; // RQ5
         rxdeact_reg <= maint_pkg::RST_RX_DEACT; // RQ6
         ctrl_reg <= maint_pkg::RST_ERR_CTRL; // RQ11
      end else begin
         lengths_reg <= lengths_next;
         txcode_reg <= txcode_next;
         rxact_reg <= rxact_next;
         rxdeact_reg <= rxdeact_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Read data is valid only in the cycle after the strobe, zero otherwise.
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            maint_pkg::OFF_LENGTHS: rdata_next = lengths_reg;
            maint_pkg::OFF_TX_CODE: rdata_next = txcode_reg;
            maint_pkg::OFF_RX_ACT: rdata_next = rxact_reg;
            maint_pkg::OFF_RX_DEACT: rdata_next = rxdeact_reg;
            maint_pkg::OFF_ERR_CTRL: rdata_next = ctrl_reg;
            maint_pkg::OFF_CNT_LOW: rdata_next = cnt.result[7:0];
            maint_pkg::OFF_CNT_HIGH: rdata_next = cnt.result[15:8];
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Field decode.

   logic [1:0] tx_len, act_len, deact_len;
   logic [2:0] tx_last;

   assign tx_len = lengths_reg[maint_pkg::TX_LEN_LSB +: maint_pkg::LEN_W];
   assign act_len = lengths_reg[maint_pkg::ACT_LEN_LSB +: maint_pkg::LEN_W];
   assign deact_len =
      lengths_reg[maint_pkg::DEACT_LEN_LSB +: maint_pkg::LEN_W];
   assign tx_last = last_idx(tx_len); // RQ1
   assign excess_zero_def = ctrl_reg[maint_pkg::EXZ_DEF_BIT];
   assign rx_activate_length = act_len; // RQ2
   assign rx_deactivate_length = deact_len; // RQ3

   ////////////////////////////////////////////////////////////////////////
   // Receive code outputs for the detectors.

   logic [7:0] act_out_reg, act_out_next;
   logic [7:0] deact_out_reg, deact_out_next;
   logic [7:0] act_mask, deact_mask;

   always_comb begin
      act_mask = code_mask(act_len);
      deact_mask = code_mask(deact_len);
      act_out_next = rxact_reg & act_mask; // RQ2 RQ5
      deact_out_next = rxdeact_reg & deact_mask; // RQ3 RQ6
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_out_reg <= 8'h00;
         deact_out_reg <= 8'h00;
      end else begin
         act_out_reg <= act_out_next;
         deact_out_reg <= deact_out_next;
      end
   end

   assign rx_activate_code = act_out_reg;
   assign rx_deactivate_code = deact_out_reg;

   ////////////////////////////////////////////////////////////////////////
   // Transmit code serializer, most significant code bit first.

   logic [2:0] tx_idx_reg, tx_idx_next;
   logic tx_bit_reg, tx_bit_next;
   logic active_reg, active_next;
   logic tx_pattern_select_hit, cur_code_bit;

   assign tx_pattern_select_hit = (tx_pattern_select == maint_pkg::TX_PATTERN_SELECT_INBAND);
   assign cur_code_bit = txcode_reg[tx_idx_reg];

   always_comb begin
      active_next = tx_pattern_select_hit; // RQ14
      tx_idx_next = tx_idx_reg;
      tx_bit_next = tx_bit_reg;
      if (!active_reg) begin
         tx_idx_next = tx_last;
         tx_bit_next = 1'b0;
      end else if (tx_bit_en) begin
         tx_bit_next = cur_code_bit; // RQ4
         // A shortened length mid-code restarts at the new top bit.
         if (tx_idx_reg == 3'h0 || tx_idx_reg > tx_last) begin
            tx_idx_next = tx_last; // RQ1
         end else begin
            tx_idx_next = tx_idx_reg - 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_idx_reg <= maint_pkg::LAST_IDX_MIN;
         tx_bit_reg <= 1'b0;
         active_reg <= 1'b0;
      end else begin
         tx_idx_reg <= tx_idx_next;
         tx_bit_reg <= tx_bit_next;
         active_reg <= active_next;
      end
   end

   assign tx_code_active = active_reg;
   assign tx_code_bit = tx_bit_reg;

   ////////////////////////////////////////////////////////////////////////
   // Rising-edge triggers: violation, logic error, count transfer.

   logic [2:0] edge_level, edge_pulse;

   assign edge_level = {ctrl_reg[maint_pkg::XFER_BIT],
      ctrl_reg[maint_pkg::LERR_BIT], ctrl_reg[maint_pkg::VIOL_BIT]};

   for (genvar g = 0; g < 3; g++) begin : g_edge
      rise_pulse u_rise (
         .clk(clk),
         .nrst(nrst),
         .level(edge_level[g]),
         .pulse(edge_pulse[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Single-shot insertion, held until the next transmit bit slot.

   maint_pkg::ins_state_t ins_reg [2];
   maint_pkg::ins_state_t ins_next [2];
   logic [1:0] strobe_reg, strobe_next;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ins_next[i] = ins_reg[i];
         strobe_next[i] = 1'b0;
         case (ins_reg[i])
            maint_pkg::INS_IDLE: begin
               if (edge_pulse[i]) begin
                  ins_next[i] = maint_pkg::INS_ARMED; // RQ7 RQ8
               end
            end
            maint_pkg::INS_ARMED: begin
               if (tx_bit_en) begin
                  strobe_next[i] = 1'b1; // RQ7 RQ8
                  // A new request in the firing cycle stays armed.
                  ins_next[i] = edge_pulse[i] ? maint_pkg::INS_ARMED
                     : maint_pkg::INS_IDLE;
               end
            end
            default: begin
               ins_next[i] = maint_pkg::INS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ins_reg[0] <= maint_pkg::INS_IDLE;
         ins_reg[1] <= maint_pkg::INS_IDLE;
         strobe_reg <= 2'h0;
      end else begin
         ins_reg[0] <= ins_next[0];
         ins_reg[1] <= ins_next[1];
         strobe_reg <= strobe_next;
      end
   end

   assign violation_strobe = strobe_reg[0];
   assign logic_error_strobe = strobe_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // One-second timer and counter control.

   logic [31:0] sec_cnt_reg, sec_cnt_next;
   logic sec_tick;
   logic auto_mode;

   assign sec_tick = (sec_cnt_reg == ONE_SEC_CYCLES - 32'h1);
   assign auto_mode = ctrl_reg[maint_pkg::MODE_BIT];

   always_comb begin
      sec_cnt_next = sec_tick ? 32'h0 : sec_cnt_reg + 32'h1;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sec_cnt_reg <= 32'h0;
      end else begin
         sec_cnt_reg <= sec_cnt_next;
      end
   end

   // Manual mode ignores the timer; automatic mode ignores the bit.
   assign cnt.transfer = auto_mode ? sec_tick : edge_pulse[2]; // RQ11 RQ15
   assign cnt.sel = maint_pkg::err_sel_t'(
      ctrl_reg[maint_pkg::ERR_SEL_LSB +: 2]); // RQ10

   error_counter u_counter (
      .clk(clk),
      .nrst(nrst),
      .cnt(cnt.counter),
      .err_logic(err_logic),
      .err_exz(err_excess_zero),
      .err_cv(err_code_violation)
   );

   assign count_full = cnt.saturated;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("Read data not zero outside a read slot.");
   resv_zero_a: assert property ( // RQ16
      reg_rd && reg_addr == maint_pkg::OFF_ERR_CTRL
      |=> reg_rdata[7] == 1'b0 && reg_rdata == $past(ctrl_reg))
      else $error("Reserved control bit read as one.");
   len_resv_a: assert property ( // RQ16
      reg_rd && reg_addr == maint_pkg::OFF_LENGTHS
      |=> reg_rdata[7:6] == 2'h0)
      else $error("Reserved length bits read as one.");
   tx_wrap_a: assert property ( // RQ1
      active_reg && tx_bit_en && tx_idx_reg == 3'h0
      |=> tx_idx_reg == $past(tx_last))
      else $error("Transmit code did not wrap at its length.");
   tx_bit_a: assert property ( // RQ4
      active_reg && tx_bit_en |=> tx_code_bit == $past(cur_code_bit))
      else $error("Transmit bit not taken from the code.");
   tx_pattern_select_sel_a: assert property ( // RQ14
      tx_code_active == $past(tx_pattern_select_hit))
      else $error("Code output not following pattern select.");
   act_mask_a: assert property ( // RQ2
      (rx_activate_code & ~$past(act_mask)) == 8'h00)
      else $error("Activate code holds bits above its length.");
   deact_mask_a: assert property ( // RQ3
      (rx_deactivate_code & ~$past(deact_mask)) == 8'h00)
      else $error("Deactivate code holds bits above its length.");
   viol_arm_a: assert property ( // RQ7
      edge_pulse[0] |=> ins_reg[0] == maint_pkg::INS_ARMED)
      else $error("Violation request not armed.");
   viol_hold_a: assert property ( // RQ7
      edge_level[0] && $past(edge_level[0])
      && ins_reg[0] == maint_pkg::INS_IDLE
      |=> !violation_strobe ##0 ins_reg[0] == maint_pkg::INS_IDLE)
      else $error("Held violation bit inserted again.");
   lerr_fire_a: assert property ( // RQ8
      ins_reg[1] == maint_pkg::INS_ARMED && tx_bit_en
      |=> logic_error_strobe ##1 !logic_error_strobe)
      else $error("Logic error strobe not single.");
   xfer_man_a: assert property ( // RQ12
      $rose(edge_level[2]) && !auto_mode |-> cnt.transfer)
      else $error("Transfer bit rise did not transfer.");
   man_only_a: assert property ( // RQ11
      !auto_mode && !$rose(edge_level[2]) |-> !cnt.transfer)
      else $error("Manual mode transferred without request.");
   auto_xfer_a: assert property ( // RQ15
      auto_mode |-> cnt.transfer == sec_tick)
      else $error("Automatic transfer not at timer expiry.");
endmodule
`default_nettype wire

//--- rtl/maint_pkg.sv
// Constants and types for the in-band loop code and error count bank.
// Notes on behaviour
// RQ1 - Transmit length field picks 5 to 8 bits.
// RQ2 - Activate length field picks 5 to 8 bits.
// RQ3 - Deactivate length field, 6 bits after reset.
// RQ4 - Transmit code is low N register bits.
// RQ5 - Activate code low N bits, resets 00001.
// RQ6 - Deactivate code low N bits, resets 001001.
// RQ7 - Violation bit rising inserts exactly one violation.
// RQ8 - Logic error bit rising inserts one error.
// RQ9 - Software clears, then sets, for another error.
// RQ10 - Error select field picks counter source.
// RQ11 - Mode bit: zero manual, one automatic.
// RQ12 - Transfer bit rising copies count, resets counter.
// RQ13 - Software clears transfer bit before setting again.
// RQ14 - Pattern select 11 sends repeating code.
// RQ15 - Automatic mode transfers at each one-second expiry.
// RQ16 - Reserved bits read zero, ignore writes.
`default_nettype none
package maint_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int LEN_W = 2;
   localparam int IDX_W = 3;
   localparam logic [7:0] OFF_LENGTHS = 8'h0E;
   localparam logic [7:0] OFF_TX_CODE = 8'h0F;
   localparam logic [7:0] OFF_RX_ACT = 8'h10;
   localparam logic [7:0] OFF_RX_DEACT = 8'h11;
   localparam logic [7:0] OFF_ERR_CTRL = 8'h12;
   localparam logic [7:0] OFF_CNT_LOW = 8'h1C;
   localparam logic [7:0] OFF_CNT_HIGH = 8'h1D;
   localparam logic [7:0] RST_LENGTHS = 8'h01;
   localparam logic [7:0] RST_TX_CODE = 8'h01;
   localparam logic [7:0] RST_RX_ACT = 8'h01;
   localparam logic [7:0] RST_RX_DEACT = 8'h09;
   localparam logic [7:0] RST_ERR_CTRL = 8'h00;
   localparam logic [7:0] MASK_LENGTHS = 8'h3F;
   localparam logic [7:0] MASK_ERR_CTRL = 8'h7F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam int TX_LEN_LSB = 4;
   localparam int ACT_LEN_LSB = 2;
   localparam int DEACT_LEN_LSB = 0;
   localparam int VIOL_BIT = 6;
   localparam int LERR_BIT = 5;
   localparam int EXZ_DEF_BIT = 4;
   localparam int ERR_SEL_LSB = 2;
   localparam int MODE_BIT = 1;
   localparam int XFER_BIT = 0;
   localparam logic [1:0] LEN_MAX = 2'h3;
   localparam logic [2:0] LAST_IDX_MIN = 3'h4;
   localparam logic [1:0] TX_PATTERN_SELECT_INBAND = 2'h3;
   localparam longint ONE_SEC_NS = 64'h0000_0000_3B9A_CA00;
   localparam longint CLK_PERIOD_NS = 64'h0000_0000_0000_0005;
   localparam int unsigned ONE_SEC_CYCLES = 32'(ONE_SEC_NS / CLK_PERIOD_NS);
   typedef enum logic [1:0] {
      ERR_SEL_LOGIC = 2'b00,
      ERR_SEL_EXZ = 2'b01,
      ERR_SEL_CV = 2'b10,
      ERR_SEL_BOTH = 2'b11
   } err_sel_t;
   typedef enum logic {
      INS_IDLE = 1'b0,
      INS_ARMED = 1'b1
   } ins_state_t;
endpackage
`default_nettype wire

//--- rtl/rise_pulse.sv
// Zero-to-one step detector on a register bit.
`default_nettype none
module rise_pulse (
   input wire logic clk,
   input wire logic nrst,
   input wire logic level,
   output logic pulse
);
   logic prev_reg;
   logic prev_next;

   always_comb begin
      prev_next = level;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   // A bit left high fires once; software must drop it to fire again.
   assign pulse = level & ~prev_reg; // RQ9
endmodule
`default_nettype wire

//--- test/inband_loop_code_and_error_count_ctrl_tb.sv
// Self-checking bench for the in-band loop code and error count bank.
`default_nettype none
module inband_loop_code_and_error_count_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] tx_pattern_select = 2'h0;
   logic tx_bit_en = 1'b0;
   logic tx_code_active, tx_code_bit, violation_strobe, logic_error_strobe;
   logic [7:0] rx_activate_code, rx_deactivate_code;
   logic [1:0] rx_activate_length, rx_deactivate_length;
   logic excess_zero_def, count_full;
   logic err_logic = 1'b0;
   logic err_excess_zero = 1'b0;
   logic err_code_violation = 1'b0;
   int bad_count = 0;
   int total_checks = 0;
   int ok;
   logic [15:0] rnd = 16'h3197;
   logic [7:0] d, code, code2, ctrl;
   logic [15:0] cnt, last;
   logic [7:0] rst_addr [9] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1C,
      8'h1D, 8'h20, 8'h13};
   logic [7:0] rst_val [9] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};

   always #2.5 clk = ~clk;

   inband_loop_code_and_error_count_ctrl #(.ONE_SEC_CYCLES(50))
   i_inband_loop_code_and_error_count_ctrl (.clk(clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_pattern_select(tx_pattern_select), .tx_bit_en(tx_bit_en),
      .tx_code_active(tx_code_active), .tx_code_bit(tx_code_bit),
      .violation_strobe(violation_strobe),
      .logic_error_strobe(logic_error_strobe),
      .rx_activate_code(rx_activate_code),
      .rx_activate_length(rx_activate_length),
      .rx_deactivate_code(rx_deactivate_code),
      .rx_deactivate_length(rx_deactivate_length),
      .excess_zero_def(excess_zero_def), .err_logic(err_logic),
      .err_excess_zero(err_excess_zero),
      .err_code_violation(err_code_violation), .count_full(count_full));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] len_mask(input logic [1:0] l);
      return 8'hFF >> (3 - l);
   endfunction
   // Both sources in one cycle must add two, not one.
   function automatic logic [1:0] err_inc(input logic [1:0] s,
      input logic l, input logic x, input logic c);
      case (s)
         2'h0: return {1'b0, l};
         2'h1: return {1'b0, x};
         2'h2: return {1'b0, c};
         default: return {1'b0, c} + {1'b0, x};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic read_count(output logic [15:0] v);
      logic [7:0] a, b;
      rd(8'h1C, a);
      rd(8'h1D, b);
      v = {b, a};
   endtask
   task automatic bit_slot;
      @(posedge clk);
      tx_bit_en <= 1'b1;
      @(posedge clk);
      tx_bit_en <= 1'b0;
      #1;
   endtask
   task automatic drive_err(input logic l, input logic x, input logic c);
      @(posedge clk);
      err_logic <= l;
      err_excess_zero <= x;
      err_code_violation <= c;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      chk({6'h0, rx_deactivate_length}, 8'h01);
      nrst <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(rst_addr[i], d);
         chk(d, rst_val[i]);
      end
      chk(rx_activate_code, 8'h01);
      chk(rx_deactivate_code, 8'h09);
      wr(8'h0E, 8'hFF);
      rd(8'h0E, d);
      chk(d, 8'h3F);
      chk({rx_activate_length, rx_deactivate_length}, 8'h0F);
      wr(8'h12, 8'h90);
      rd(8'h12, d);
      chk(d, 8'h10);
      chk({7'h0, excess_zero_def}, 8'h01);
      wr(8'h12, 8'h00);
      wr(8'h20, 8'hFF);
      rd(8'h20, d);
      chk(d, 8'h00);
      // Every length, with a random code, on both receive and transmit.
      for (int l = 0; l < 4; l++) begin
         rnd = lfsr(rnd);
         code = rnd[7:0];
         code2 = rnd[15:8];
         wr(8'h0E, {2'h0, l[1:0], l[1:0], l[1:0]});
         wr(8'h0F, code);
         wr(8'h10, code2);
         wr(8'h11, ~code);
         rd(8'h10, d);
         chk(d, code2);
         chk(rx_activate_code, code2 & len_mask(l[1:0]));
         chk(rx_deactivate_code, ~code & len_mask(l[1:0]));
         chk({6'h0, rx_activate_length}, {6'h0, l[1:0]});
         @(posedge clk);
         tx_pattern_select <= 2'h3;
         repeat (2) @(posedge clk);
         #1;
         chk({7'h0, tx_code_active}, 8'h01);
         for (int i = 0; i < 2 * (l + 5); i++) begin
            bit_slot();
            chk({7'h0, tx_code_bit},
               {7'h0, code[l + 4 - i % (l + 5)]});
         end
         @(posedge clk);
         tx_pattern_select <= 2'(l % 3);
         repeat (2) @(posedge clk);
         #1;
         chk({6'h0, tx_code_active, tx_code_bit}, 8'h00);
      end
      // Single insertions: a held bit inserts nothing further.
      for (int k = 0; k < 2; k++) begin
         ctrl = (k == 0) ? 8'h40 : 8'h20;
         wr(8'h12, ctrl);
         for (int r = 0; r < 2; r++) begin
            bit_slot();
            chk({6'h0, violation_strobe, logic_error_strobe},
               (r == 0) ? {6'h0, ctrl[6:5]} : 8'h00);
         end
         wr(8'h12, 8'h00);
         wr(8'h12, ctrl);
         bit_slot();
         chk({6'h0, violation_strobe, logic_error_strobe},
            {6'h0, ctrl[6:5]});
         wr(8'h12, 8'h00);
      end
      // Manual transfers for every error source.
      for (int s = 0; s < 4; s++) begin
         ctrl = {4'h0, s[1:0], 2'b00};
         wr(8'h12, ctrl);
         wr(8'h12, ctrl | 8'h01);
         wr(8'h12, ctrl);
         cnt = 16'h0000;
         for (int i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            drive_err(rnd[0], rnd[1], rnd[2]);
            cnt = cnt + 16'(err_inc(s[1:0], rnd[0], rnd[1], rnd[2]));
         end
         drive_err(1'b0, 1'b0, 1'b0);
         wr(8'h12, ctrl | 8'h01);
         read_count(last);
         chk(last[7:0], cnt[7:0]);
         chk(last[15:8], cnt[15:8]);
         drive_err(1'b1, 1'b1, 1'b1);
         drive_err(1'b0, 1'b0, 1'b0);
         wr(8'h12, ctrl | 8'h01);
         read_count(cnt);
         chk(cnt[7:0], last[7:0]);
      end
      // Two errors a cycle fill the counter, which must stick at the top.
      // The transfer also empties the count that the timer checks rely on.
      wr(8'h12, 8'h0C);
      chk({7'h0, count_full}, 8'h00);
      drive_err(1'b0, 1'b1, 1'b1);
      repeat (32800) @(posedge clk);
      drive_err(1'b0, 1'b0, 1'b0);
      chk({7'h0, count_full}, 8'h01);
      wr(8'h12, 8'h0D);
      read_count(cnt);
      chk(cnt[7:0], 8'hFF);
      chk(cnt[15:8], 8'hFF);
      chk({7'h0, count_full}, 8'h00);
      // Timer has no effect in manual mode, then drives transfers in auto.
      wr(8'h12, 8'h00);
      read_count(last);
      drive_err(1'b1, 1'b0, 1'b0);
      drive_err(1'b0, 1'b0, 1'b0);
      repeat (120) @(posedge clk);
      read_count(cnt);
      chk(cnt[7:0], last[7:0]);
      wr(8'h12, 8'h02);
      for (int e = 1; e >= 0; e--) begin
         ok = 0;
         for (int n = 0; n < 80 && ok == 0; n++) begin
            read_count(cnt);
            if (cnt === 16'(e)) begin
               ok = 1;
            end
         end
         chk({7'h0, ok[0]}, 8'h01);
         if (ok == 0) begin
            stop_test();
         end
      end
      stop_test();
   end
endmodule
`default_nettype wire
